// ===== pkg/dsl_pkg.sv
// Shared constants for the sample latch and sleep front end
package dsl_pkg;
  localparam int SAMPLE_W = 12;
  localparam int CODE_MAX = 4095;
  localparam int CODE_SPAN = 4096;
  localparam int FIFO_DEPTH = 16;
  localparam int MAX_RATE_MSPS = 125;
  localparam int CLK_RATE_MHZ = 20;
  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam logic [11:0] CODE_FULL = 12'hFFF;
  localparam logic SLEEP_DEFAULT = 1'b0;
endpackage

// ===== rtl/dsl_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module dsl_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // Clock, reset and enable
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("dsl_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // Honest flags from the occupancy count
  assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rp_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Next pointers, count and storage
  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = in_data_i;
      wp_nxt = wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = rp_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Storage is not reset; the count guards against stale words
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce_i) begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (ce_i) begin
      mem_r <= mem_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/dsl_front.sv
// Sample word capture, code update and sleep control of the converter front end
`timescale 1ns/10ps
`default_nettype none
module dsl_front #(
  parameter int WIDTH = dsl_pkg::SAMPLE_W,
  parameter int DEPTH = dsl_pkg::FIFO_DEPTH
) (
  // Clock, reset and enable
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Sample source
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  input wire logic [WIDTH-1:0] sample_word_i,
  // Sleep control, with driven flag modelling the pull-down
  input wire logic sleep_i,
  input wire logic sleep_driven_i,
  // Converter output codes
  output logic [WIDTH-1:0] current_out_true_o,
  output logic [WIDTH-1:0] current_out_comp_o,
  output logic outputs_on_o,
  output logic update_o
);
  initial begin
    if (WIDTH != dsl_pkg::SAMPLE_W || DEPTH < 2) begin
      $error("dsl_front: WIDTH must be 12 and DEPTH at least 2");
    end
  end

  // Complement code for the complement output only
  function automatic logic [WIDTH-1:0] comp_code(input logic [WIDTH-1:0] c);
    comp_code = ~c;
  endfunction

  logic fifo_valid;
  logic fifo_ready;
  logic [WIDTH-1:0] fifo_data;
  logic sleep_lvl;
  logic [WIDTH-1:0] held_r, held_nxt;
  logic upd_r, upd_nxt;

  // Buffer between the source and the latch; absorbs bursts
  dsl_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(sample_valid_i),
    .in_ready_o(sample_ready_o),
    .in_data_i(sample_word_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready),
    .out_data_o(fifo_data)
  );

  // Floating sleep pin resolves low, like the pull-down
  assign sleep_lvl = sleep_driven_i ? sleep_i : dsl_pkg::SLEEP_DEFAULT;

  // Drain stalls in sleep so queued samples are kept, not lost
  assign fifo_ready = !sleep_lvl;

  // Next held word: one word per rising edge, straight binary
  always_comb begin
    held_nxt = held_r;
    upd_nxt = 1'b0;
    if (fifo_valid && fifo_ready) begin
      held_nxt = fifo_data;
      upd_nxt = 1'b1;
    end
  end

  // Held register is the slave stage; the FIFO head is the master
  // One word per edge at any clock rate or duty cycle; timing limits are electrical
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      held_r <= dsl_pkg::CODE_ZERO;
      upd_r <= 1'b0;
    end else if (ce_i) begin
      held_r <= held_nxt;
      upd_r <= upd_nxt;
    end
  end

  // Sleep gates outputs without the clock, so power-down is immediate
  always_comb begin
    if (sleep_lvl) begin
      current_out_true_o = dsl_pkg::CODE_ZERO;
      current_out_comp_o = dsl_pkg::CODE_ZERO;
      outputs_on_o = 1'b0;
    end else begin
      current_out_true_o = held_r;
      current_out_comp_o = comp_code(held_r);
      outputs_on_o = 1'b1;
    end
  end

  assign update_o = upd_r;
endmodule
`default_nettype wire

// ===== verification/dsl_front_monitor.sv
// Port checker for codes, sleep gate and update pulse
`timescale 1ns/10ps
`default_nettype none
module dsl_front_monitor #(parameter int WIDTH = 12, parameter int DEPTH = 16) (
  // Watched ports
  input wire logic core_clk_i, rst_i, ce_i, sample_valid_i, sample_ready_o,
  input wire logic [WIDTH-1:0] sample_word_i, current_out_true_o, current_out_comp_o,
  input wire logic sleep_i, sleep_driven_i, outputs_on_o, update_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Sleep only counts while something drives the pin
  sequence s_asleep; sleep_i && sleep_driven_i; endsequence
  a_comp_inverse:
    assert property (outputs_on_o |-> current_out_comp_o == ~current_out_true_o) else $error("comp");
  a_sleep_off:
    assert property (s_asleep |-> !outputs_on_o && current_out_true_o == 0 && current_out_comp_o == 0)
    else $error("sleep");
  a_float_awake:
    assert property (!sleep_driven_i |-> outputs_on_o) else $error("float");
  a_wake_level:
    assert property (!sleep_i |-> outputs_on_o) else $error("wake");
  a_sleep_stall:
    assert property (s_asleep |=> !update_o) else $error("stall");
  a_hold_code:
    assert property (outputs_on_o && $past(outputs_on_o) && !update_o |-> $stable(current_out_true_o))
    else $error("hold");
  a_update_enabled:
    assert property (update_o |-> $past(ce_i)) else $error("update");
  a_reset_state:
    assert property ($past(rst_i) |-> sample_ready_o && current_out_true_o == 0 && !update_o)
    else $error("reset");
endmodule
`default_nettype wire

// ===== verification/dsl_src.sv
// Sample source model holding each word until taken
`timescale 1ns/10ps
`default_nettype none
module dsl_src (
  input wire logic core_clk_i, sample_ready_o,
  output logic sample_valid_i,
  output logic [11:0] sample_word_i
);
  initial begin
    sample_valid_i = 1'b0;
    sample_word_i = 12'h000;
  end
  // At most one word per edge; idle word inverted so stale data never passes
  task automatic send(input logic [11:0] w, input int gap);
    logic r;
    repeat (gap) @(posedge core_clk_i);
    #1 sample_valid_i = 1'b1;
    sample_word_i = w;
    do begin r = sample_ready_o; @(posedge core_clk_i); end while (r !== 1'b1);
    #1 sample_valid_i = 1'b0;
    sample_word_i = ~w;
  endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the sample front end
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic core_clk_i = 0, rst_i = 1, ce_i = 1, sleep_i = 0, sleep_driven_i = 1;
  logic sample_valid_i, sample_ready_o, outputs_on_o, update_o;
  logic [11:0] sample_word_i, current_out_true_o, current_out_comp_o;
  logic [11:0] exp_q[$];
  int err_count = 0, checks = 0, cyc = 0;
  dsl_front dut (.*);
  dsl_src src (.*);
  always #25 core_clk_i = ~core_clk_i;
  // Hang guard
  always @(posedge core_clk_i) if (++cyc == 2000) begin err_count++; summarize(); end
  task automatic chk(input logic [11:0] seen, exp);
    checks++;
    if (seen !== exp) begin err_count++; $display("[ERR] %0t %h/%h", $time, seen, exp); end
  endtask
  // Each update pulse shows the oldest owed word
  always @(negedge core_clk_i) if (update_o === 1'b1 && exp_q.size() > 0) begin
    chk(current_out_true_o, exp_q[0]);
    chk(current_out_comp_o, ~exp_q.pop_front());
  end
  task automatic put(input logic [11:0] w, input int g);
    exp_q.push_back(w);
    src.send(w, g);
  endtask
  task automatic drain();
    for (int i = 0; i < 60 && exp_q.size() > 0; i++) @(posedge core_clk_i);
    chk(12'(exp_q.size()), 12'h000);
  endtask
  task automatic t_codes();
    logic [11:0] tab[5] = '{12'h000, 12'hFFF, 12'h800, 12'h001, 12'hA5C};
    foreach (tab[i]) put(tab[i], 0);
    drain();
    $display("codes done");
  endtask
  // Backlog builds while asleep, then drains in order after an open-pin wake
  task automatic t_sleep();
    @(posedge core_clk_i);
    #1 sleep_i = 1;
    #1 chk(current_out_comp_o, 12'h000);
    chk(12'(outputs_on_o), 12'h000);
    for (int i = 0; i < 16; i++) put(12'h100 + 12'(i), i % 2);
    #1 chk(sample_ready_o, 1'b0);
    @(posedge core_clk_i);
    #1 sleep_driven_i = 0;
    #1 chk(current_out_true_o, 12'hA5C);
    chk(12'(outputs_on_o), 12'h001);
    drain();
    $display("sleep done");
  endtask
  task automatic summarize();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk_i);
    #1 rst_i = 0;
    chk(current_out_comp_o, 12'hFFF);
    t_codes();
    t_sleep();
    summarize();
  end
endmodule
bind dsl_front dsl_front_monitor #(.WIDTH(WIDTH), .DEPTH(DEPTH)) mon (.*);
`default_nettype wire
